// *** logic/td_pkg.sv ***
// Package for the transfer descriptor engine: register map, fields, codes.
// Assumes a 250 MHz clock and a plain address/strobe register port.
package td_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_DESC_CTRL  = 8'h00;
	localparam logic [7:0] OFF_DESC_COUNT = 8'h04;
	localparam logic [7:0] OFF_BUF_BASE   = 8'h08;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h0C;
	localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h10;
	localparam logic [7:0] OFF_IRQ_ENABLE = 8'h14;

	// Descriptor control word fields
	localparam int F_LIMIT_LSB = 0;
	localparam int F_OPF       = 10;
	localparam int F_FORMAT    = 11;
	localparam int F_SPEED     = 12;
	localparam int F_LAST      = 13;
	localparam int F_EP_LSB    = 14;
	localparam int F_ADDR_LSB  = 18;
	localparam int F_DIR_LSB   = 25;
	localparam int F_TOGGLE    = 27;
	localparam int F_ACTIVE    = 28;

	// Descriptor count word fields
	localparam int F_TOTAL_LSB = 0;
	localparam int F_MOVED_LSB = 16;
	localparam int F_CODE_LSB  = 28;

	// Interrupt status bits
	localparam int IRQ_DONE  = 0;
	localparam int IRQ_LIST  = 1;
	localparam int IRQ_ERROR = 2;

	// Result codes
	localparam logic [3:0] CODE_OK         = 4'h0;
	localparam logic [3:0] CODE_BAD_PID    = 4'h7;
	localparam logic [3:0] CODE_STORE_SLOW = 4'hC;
	localparam logic [3:0] CODE_FETCH_SLOW = 4'hD;

	// Token directions
	localparam logic [1:0] DIR_SETUP = 2'h0;
	localparam logic [1:0] DIR_OUT   = 2'h1;
	localparam logic [1:0] DIR_IN    = 2'h2;
	localparam logic [1:0] DIR_RSVD  = 2'h3;

	// Reset values
	localparam logic [31:0] RST_DESC_CTRL = 32'h0000_0000;
	localparam logic [9:0]  RST_TOTAL     = 10'h000;
	localparam logic [9:0]  RST_BASE      = 10'h000;
	localparam logic [2:0]  RST_IRQ       = 3'h0;

	// Header length ahead of the payload, bytes
	localparam logic [11:0] HEADER_BYTES = 12'h008;

	// Frame timing
	localparam int FRAME_TIME_NS = 1000000;
	localparam int CLK_PERIOD_NS = 4;
	localparam int FRAME_CYCLES  = FRAME_TIME_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_DONE} engine_state_e;

endpackage : td_pkg

// *** logic/frame_tick.sv ***
// Frame timer: one-cycle tick every frame period.
// Assumes a single free-running clock and synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module frame_tick #(
	parameter int FRAME_CYCLES = td_pkg::FRAME_CYCLES
) (
	input  wire logic clk,
	input  wire logic rst,
	output var  logic tick
);
	logic [17:0] count;
	wire         at_end = (count == 18'(FRAME_CYCLES - 1));

	always_ff @(posedge clk) begin
		if (rst) begin
			count <= 18'h00000;
			tick  <= 1'b0;
		end else begin
			count <= at_end ? 18'h00000 : count + 18'h00001;
			tick  <= at_end;
		end
	end
endmodule : frame_tick
`default_nettype wire

// *** logic/td_engine.sv ***
// Transfer descriptor engine: runs one descriptor against a USB link.
// Assumes link and memory handshakes come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Result code zero means no error
// - Store too slow on IN gives 1100
// - Fetch too slow on OUT gives 1101
// - Active cleared when descriptor completes
// - Toggle holds expected PID, flipped after each good non-iso packet
// - Ten-bit packet limit caps each packet
// - Seven-bit device address targets function
// - Last marker ends the descriptor list
// - Speed 0 full, 1 low
// - Ten-bit byte count is descriptor total
// - Bytes actually moved written back
// - One-per-frame option is 0 after reset
// - Option limits non-iso descriptors to one transaction per frame
// - Header and payload start on 4-byte boundary
module td_engine #(
	parameter int FRAME_CYCLES = td_pkg::FRAME_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output var  logic [31:0] reg_rdata,
	output var  logic        irq,
	output var  logic        xact_start,
	output var  logic [1:0]  token_direction,
	output var  logic [6:0]  token_address,
	output var  logic [3:0]  token_endpoint,
	output var  logic [9:0]  token_length,
	output var  logic        token_low_speed,
	output var  logic        token_iso,
	output var  logic        token_data1,
	output var  logic [11:0] mem_addr,
	input  wire logic        xact_done,
	input  wire logic [3:0]  xact_code,
	input  wire logic        link_rx_strobe,
	input  wire logic        mem_store_ready,
	input  wire logic        link_tx_strobe,
	input  wire logic        mem_fetch_valid
);
	td_pkg::engine_state_e state;
	td_pkg::engine_state_e next_state;

	logic [31:0] desc_ctrl;
	logic [9:0]  descriptor_byte_count;
	logic [9:0]  bytes_moved_count;
	logic [3:0]  result_code;
	logic [9:0]  buf_base;
	logic [2:0]  irq_status;
	logic [2:0]  irq_enable;
	logic [9:0]  pkt_count;
	logic        store_too_slow_error;
	logic        fetch_too_slow_error;
	logic        sent_this_frame;
	logic        frame_pulse;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	// Descriptor field decode
	wire [9:0] packet_byte_limit    = desc_ctrl[td_pkg::F_LIMIT_LSB +: 10];
	wire       one_per_frame_option = desc_ctrl[td_pkg::F_OPF];
	wire       format_iso           = desc_ctrl[td_pkg::F_FORMAT];
	wire       speed_low            = desc_ctrl[td_pkg::F_SPEED];
	wire       last_in_list         = desc_ctrl[td_pkg::F_LAST];
	wire [3:0] endpoint_index       = desc_ctrl[td_pkg::F_EP_LSB +: 4];
	wire [6:0] device_bus_address   = desc_ctrl[td_pkg::F_ADDR_LSB +: 7];
	wire [1:0] dir_field            = desc_ctrl[td_pkg::F_DIR_LSB +: 2];
	wire       toggle               = desc_ctrl[td_pkg::F_TOGGLE];
	wire       active               = desc_ctrl[td_pkg::F_ACTIVE];

	// Register port decode
	wire wr_ctrl  = reg_wr && hit(reg_addr, td_pkg::OFF_DESC_CTRL);
	wire wr_count = reg_wr && hit(reg_addr, td_pkg::OFF_DESC_COUNT);
	wire wr_base  = reg_wr && hit(reg_addr, td_pkg::OFF_BUF_BASE);
	wire wr_clear = reg_wr && hit(reg_addr, td_pkg::OFF_IRQ_CLEAR);
	wire wr_en    = reg_wr && hit(reg_addr, td_pkg::OFF_IRQ_ENABLE);

	wire [31:0] count_word = {result_code, 2'b00, bytes_moved_count, 6'h00,
		descriptor_byte_count};
	wire [31:0] read_mux =
		hit(reg_addr, td_pkg::OFF_DESC_CTRL)  ? desc_ctrl :
		hit(reg_addr, td_pkg::OFF_DESC_COUNT) ? count_word :
		hit(reg_addr, td_pkg::OFF_BUF_BASE)   ? {20'h00000, buf_base, 2'b00} :
		hit(reg_addr, td_pkg::OFF_IRQ_STATUS) ? {29'h0, irq_status} :
		hit(reg_addr, td_pkg::OFF_IRQ_ENABLE) ? {29'h0, irq_enable} : 32'h0000_0000;

	// Transaction sizing and completion
	wire [9:0]  remaining  = descriptor_byte_count - bytes_moved_count;
	wire [9:0]  pkt_len    = (remaining < packet_byte_limit) ? remaining
		: packet_byte_limit;
	wire        frame_hold = one_per_frame_option && !format_iso && sent_this_frame;
	wire        in_wait    = (state == td_pkg::ST_WAIT);
	wire        pkt_end    = in_wait && xact_done;
	wire        dir_in     = (dir_field == td_pkg::DIR_IN);
	wire        rx_byte    = in_wait && link_rx_strobe && dir_in;
	wire        tx_byte    = in_wait && link_tx_strobe && !dir_in;
	wire        overrun    = store_too_slow_error || (rx_byte && !mem_store_ready);
	wire        underrun   = fetch_too_slow_error || (tx_byte && !mem_fetch_valid);
	wire [3:0]  pkt_code   = overrun ? td_pkg::CODE_STORE_SLOW :
		underrun ? td_pkg::CODE_FETCH_SLOW : xact_code;
	wire        pkt_ok     = (pkt_code == td_pkg::CODE_OK);
	wire [9:0]  moved_sum  = bytes_moved_count + pkt_count;
	wire        desc_end   = !pkt_ok || format_iso || (moved_sum >= descriptor_byte_count)
		|| (pkt_count < token_length);
	wire        bad_dir    = (dir_field == td_pkg::DIR_RSVD);
	// Payload follows header, both on 4-byte boundaries
	wire [11:0] payload_at = {buf_base, 2'b00} + td_pkg::HEADER_BYTES;
	wire [2:0]  events     = {state == td_pkg::ST_DONE && result_code != td_pkg::CODE_OK,
		state == td_pkg::ST_DONE && last_in_list, state == td_pkg::ST_DONE};

	always_comb begin
		next_state = state;
		case (state)
			td_pkg::ST_IDLE: begin
				if (active && !frame_hold) begin
					next_state = bad_dir ? td_pkg::ST_DONE : td_pkg::ST_ISSUE;
				end
			end
			td_pkg::ST_ISSUE: next_state = td_pkg::ST_WAIT;
			td_pkg::ST_WAIT: begin
				if (xact_done) begin
					next_state = desc_end ? td_pkg::ST_DONE : td_pkg::ST_IDLE;
				end
			end
			td_pkg::ST_DONE: next_state = td_pkg::ST_IDLE;
			default: next_state = td_pkg::ST_IDLE;
		endcase
	end

	frame_tick #(
		.FRAME_CYCLES(FRAME_CYCLES)
	) u_frame (
		.clk (clk),
		.rst (rst),
		.tick(frame_pulse)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= td_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Descriptor control word; software write wins over hardware update
	always_ff @(posedge clk) begin
		if (rst) begin
			desc_ctrl <= td_pkg::RST_DESC_CTRL;
		end else if (wr_ctrl) begin
			desc_ctrl <= reg_wdata;
		end else begin
			if (state == td_pkg::ST_DONE) begin
				desc_ctrl[td_pkg::F_ACTIVE] <= 1'b0;
			end
			if (pkt_end && pkt_ok && !format_iso) begin
				desc_ctrl[td_pkg::F_TOGGLE] <= !toggle;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			descriptor_byte_count <= td_pkg::RST_TOTAL;
			buf_base              <= td_pkg::RST_BASE;
		end else begin
			if (wr_count) begin
				descriptor_byte_count <= reg_wdata[td_pkg::F_TOTAL_LSB +: 10];
			end
			if (wr_base) begin
				buf_base <= reg_wdata[11:2];
			end
		end
	end

	// Write-back of moved bytes and result
	always_ff @(posedge clk) begin
		if (rst) begin
			bytes_moved_count <= 10'h000;
			result_code       <= td_pkg::CODE_OK;
		end else if (wr_ctrl && reg_wdata[td_pkg::F_ACTIVE]) begin
			bytes_moved_count <= 10'h000;
			result_code       <= td_pkg::CODE_OK;
		end else if (pkt_end) begin
			bytes_moved_count <= moved_sum;
			result_code       <= pkt_code;
		end else if (state == td_pkg::ST_IDLE && active && !frame_hold && bad_dir) begin
			result_code <= td_pkg::CODE_BAD_PID;
		end
	end

	// Per-packet byte count and memory pacing errors
	always_ff @(posedge clk) begin
		if (rst || state == td_pkg::ST_ISSUE) begin
			pkt_count            <= 10'h000;
			store_too_slow_error <= 1'b0;
			fetch_too_slow_error <= 1'b0;
		end else begin
			if ((rx_byte && mem_store_ready) || (tx_byte && mem_fetch_valid)) begin
				pkt_count <= pkt_count + 10'h001;
			end
			store_too_slow_error <= overrun;
			fetch_too_slow_error <= underrun;
		end
	end

	// One-per-frame bookkeeping; a start in the tick cycle still counts
	always_ff @(posedge clk) begin
		if (rst) begin
			sent_this_frame <= 1'b0;
		end else if (state == td_pkg::ST_ISSUE) begin
			sent_this_frame <= 1'b1;
		end else if (frame_pulse) begin
			sent_this_frame <= 1'b0;
		end
	end

	// Token outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			xact_start      <= 1'b0;
			token_direction <= td_pkg::DIR_SETUP;
			token_address   <= 7'h00;
			token_endpoint  <= 4'h0;
			token_length    <= 10'h000;
			token_low_speed <= 1'b0;
			token_iso       <= 1'b0;
			token_data1     <= 1'b0;
		end else begin
			xact_start <= (next_state == td_pkg::ST_ISSUE);
			if (next_state == td_pkg::ST_ISSUE) begin
				token_direction <= dir_field;
				token_address   <= device_bus_address;
				token_endpoint  <= endpoint_index;
				token_length    <= pkt_len;
				token_low_speed <= speed_low;
				token_iso       <= format_iso;
				token_data1     <= toggle;
			end
		end
	end

	// Buffer address walks the payload byte by byte
	always_ff @(posedge clk) begin
		if (rst) begin
			mem_addr <= 12'h000;
		end else if (next_state == td_pkg::ST_ISSUE) begin
			mem_addr <= payload_at + {2'b00, bytes_moved_count};
		end else if ((rx_byte && mem_store_ready) || (tx_byte && mem_fetch_valid)) begin
			mem_addr <= mem_addr + 12'h001;
		end
	end

	// Interrupt status: set wins over clear
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_status <= td_pkg::RST_IRQ;
			irq_enable <= td_pkg::RST_IRQ;
			irq        <= 1'b0;
		end else begin
			irq_status <= (irq_status & ~(wr_clear ? reg_wdata[2:0] : 3'h0)) | events;
			if (wr_en) begin
				irq_enable <= reg_wdata[2:0];
			end
			irq <= |(irq_status & irq_enable);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			reg_rdata <= read_mux;
		end
	end

	// Helper: transactions started in the current frame
	logic [1:0] frame_starts;
	always_ff @(posedge clk) begin
		if (rst) begin
			frame_starts <= 2'h0;
		end else if (frame_pulse) begin
			frame_starts <= {1'b0, xact_start};
		end else if (xact_start && frame_starts != 2'h3) begin
			frame_starts <= frame_starts + 2'h1;
		end
	end

	sequence s_pkt_ok;
		pkt_end && pkt_ok;
	endsequence

	sequence s_done_last;
		state == td_pkg::ST_DONE && last_in_list;
	endsequence

	ok_code_a: assert property (@(posedge clk) disable iff (rst)
		s_pkt_ok |=> result_code == 4'h0)
		else $error("Clean packet did not leave result zero");
	overrun_code_a: assert property (@(posedge clk) disable iff (rst)
		pkt_end && overrun |=> result_code == 4'hC ##1 !active)
		else $error("Store overrun not reported as 1100");
	underrun_code_a: assert property (@(posedge clk) disable iff (rst)
		pkt_end && underrun && !overrun |=> result_code == 4'hD)
		else $error("Fetch underrun not reported as 1101");
	active_clear_a: assert property (@(posedge clk) disable iff (rst)
		state == td_pkg::ST_DONE && !wr_ctrl |=> !active)
		else $error("Active left set after completion");
	toggle_flip_a: assert property (@(posedge clk) disable iff (rst)
		(s_pkt_ok and (!format_iso && !wr_ctrl)) |=> toggle != $past(toggle))
		else $error("Toggle not advanced after good packet");
	packet_limit_a: assert property (@(posedge clk) disable iff (rst)
		xact_start |-> token_length <= packet_byte_limit)
		else $error("Packet length above limit");
	token_target_a: assert property (@(posedge clk) disable iff (rst)
		$rose(xact_start) |-> token_address == device_bus_address
		&& token_endpoint == endpoint_index)
		else $error("Token address or endpoint wrong");
	speed_select_a: assert property (@(posedge clk) disable iff (rst)
		xact_start |-> token_low_speed == speed_low)
		else $error("Token speed does not follow descriptor");
	list_end_a: assert property (@(posedge clk) disable iff (rst)
		s_done_last |=> irq_status[td_pkg::IRQ_LIST])
		else $error("Last descriptor did not flag list end");
	moved_bound_a: assert property (@(posedge clk) disable iff (rst)
		s_pkt_ok |=> bytes_moved_count <= descriptor_byte_count)
		else $error("Moved count beyond descriptor total");
	dir_refuse_a: assert property (@(posedge clk) disable iff (rst)
		xact_start |-> token_direction != 2'h3)
		else $error("Reserved direction issued");
	frame_once_a: assert property (@(posedge clk) disable iff (rst)
		one_per_frame_option && !format_iso && xact_start |-> frame_starts == 2'h0)
		else $error("Second transaction in one frame");
	payload_align_a: assert property (@(posedge clk) disable iff (rst)
		xact_start && bytes_moved_count[1:0] == 2'h0 |-> mem_addr[1:0] == 2'h0)
		else $error("Payload start not on 4-byte boundary");
endmodule : td_engine
`default_nettype wire

// *** testbench/usb_link_model.sv ***
// Link and memory partner for the descriptor engine.
// Assumes the engine clock and one byte per strobe.
`timescale 1ns/100ps
`default_nettype none
module usb_link_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       xact_start,
	input  wire logic [1:0] token_direction,
	input  wire logic [9:0] token_length,
	input  wire logic [9:0] max_bytes,
	input  wire logic       mem_fault,
	input  wire logic [3:0] fault_code,
	output var  logic       xact_done,
	output var  logic [3:0] xact_code,
	output var  logic       link_rx_strobe,
	output var  logic       link_tx_strobe,
	output var  logic       mem_store_ready,
	output var  logic       mem_fetch_valid
);
	logic       busy;
	logic       is_in;
	logic [9:0] left;
	wire  [9:0] send_len = (token_length < max_bytes) ? token_length : max_bytes;
	// Memory stalls only when told to
	assign mem_store_ready = ~mem_fault;
	assign mem_fetch_valid = ~mem_fault;
	// Code lines show the inverse outside the done pulse
	assign xact_code = xact_done ? fault_code : ~fault_code;
	always_ff @(posedge clk) begin
		if (rst) begin
			busy           <= 1'b0;
			is_in          <= 1'b0;
			left           <= 10'h000;
			xact_done      <= 1'b0;
			link_rx_strobe <= 1'b0;
			link_tx_strobe <= 1'b0;
		end else begin
			xact_done      <= 1'b0;
			link_rx_strobe <= 1'b0;
			link_tx_strobe <= 1'b0;
			if (xact_start) begin
				busy  <= 1'b1;
				is_in <= (token_direction == td_pkg::DIR_IN);
				left  <= send_len;
			end else if (busy && left != 10'h000) begin
				link_rx_strobe <= is_in;
				link_tx_strobe <= ~is_in;
				left           <= left - 10'h001;
			end else if (busy) begin
				busy      <= 1'b0;
				xact_done <= 1'b1;
			end
		end
	end
endmodule : usb_link_model
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench for the descriptor engine.
// Assumes the link model stands on the transaction side.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	typedef struct packed {
		logic [1:0] dir;
		logic [9:0] total;
		logic [9:0] limit;
		logic [9:0] maxb;
		logic       fault;
		logic [3:0] fcode;
		logic       iso;
		logic [3:0] code;
		logic [9:0] moved;
		logic       tog;
		logic [3:0] starts;
	} row_s;
	row_s rows [9] = '{
		'{2'h2, 10'h004, 10'h008, 10'h3FF, 1'b0, 4'h0, 1'b0, 4'h0, 10'h004, 1'b1, 4'h1},
		'{2'h1, 10'h00A, 10'h004, 10'h3FF, 1'b0, 4'h0, 1'b0, 4'h0, 10'h00A, 1'b1, 4'h3},
		'{2'h0, 10'h003, 10'h008, 10'h3FF, 1'b0, 4'h0, 1'b0, 4'h0, 10'h003, 1'b1, 4'h1},
		'{2'h2, 10'h008, 10'h008, 10'h002, 1'b0, 4'h0, 1'b0, 4'h0, 10'h002, 1'b1, 4'h1},
		'{2'h2, 10'h004, 10'h008, 10'h3FF, 1'b1, 4'h0, 1'b0, 4'hC, 10'h000, 1'b0, 4'h1},
		'{2'h1, 10'h004, 10'h008, 10'h3FF, 1'b1, 4'h0, 1'b0, 4'hD, 10'h000, 1'b0, 4'h1},
		'{2'h2, 10'h004, 10'h008, 10'h3FF, 1'b0, 4'h5, 1'b0, 4'h5, 10'h000, 1'b0, 4'h1},
		'{2'h3, 10'h004, 10'h008, 10'h3FF, 1'b0, 4'h0, 1'b0, 4'h7, 10'h000, 1'b0, 4'h0},
		'{2'h2, 10'h008, 10'h004, 10'h3FF, 1'b0, 4'h0, 1'b1, 4'h0, 10'h004, 1'b0, 4'h1}};
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic        irq, xact_start, token_low_speed, token_iso, token_data1, xact_done;
	logic [1:0]  token_direction;
	logic [6:0]  token_address;
	logic [3:0]  token_endpoint, xact_code;
	logic [9:0]  token_length;
	logic [11:0] mem_addr;
	logic        link_rx_strobe, link_tx_strobe, mem_store_ready, mem_fetch_valid;
	logic [9:0]  mb = 10'h3FF;
	logic        mf = 1'b0;
	logic [3:0]  fc = 4'h0;
	logic [31:0] v, ctl, tk;
	row_s        r;
	int          fails = 0, total_checks = 0, starts = 0, cyc = 0, t_first, t_last;
	td_engine #(.FRAME_CYCLES(200)) dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.irq(irq), .xact_start(xact_start), .token_direction(token_direction),
		.token_address(token_address), .token_endpoint(token_endpoint),
		.token_length(token_length), .token_low_speed(token_low_speed), .token_iso(token_iso),
		.token_data1(token_data1), .mem_addr(mem_addr), .xact_done(xact_done),
		.xact_code(xact_code), .link_rx_strobe(link_rx_strobe),
		.mem_store_ready(mem_store_ready), .link_tx_strobe(link_tx_strobe),
		.mem_fetch_valid(mem_fetch_valid));
	usb_link_model partner_u (.clk(clk), .rst(rst), .xact_start(xact_start),
		.token_direction(token_direction), .token_length(token_length), .max_bytes(mb),
		.mem_fault(mf), .fault_code(fc), .xact_done(xact_done), .xact_code(xact_code),
		.link_rx_strobe(link_rx_strobe), .link_tx_strobe(link_tx_strobe),
		.mem_store_ready(mem_store_ready), .mem_fetch_valid(mem_fetch_valid));
	initial begin
		forever #2 clk = ~clk;
	end
	// Token capture at the first start of each descriptor
	always @(posedge clk) begin
		cyc++;
		if (xact_start === 1'b1) begin
			starts++;
			t_last = cyc;
			if (starts == 1) begin
				t_first = cyc;
				tk = {token_data1, token_iso, token_low_speed, token_endpoint, token_address,
					token_direction, token_length};
			end
		end
	end
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task end_of_test;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task do_reset;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
	endtask : do_reset
	task wait_irq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		check("irq_wait", n < 3000, 1'b1);
	endtask : wait_irq
	task irq_seq(input logic [2:0] en, input logic exp);
		wr(td_pkg::OFF_IRQ_ENABLE, 32'(en));
		repeat (3) @(posedge clk);
		#1 check("irq", irq, exp);
	endtask : irq_seq
	function automatic logic [31:0] mk_ctrl(input logic [9:0] lim, input logic opf, fmt, spd,
		lst, input logic [3:0] ep, input logic [6:0] ad, input logic [1:0] dr, input logic act);
		return 32'(lim) | 32'(opf) << td_pkg::F_OPF | 32'(fmt) << td_pkg::F_FORMAT
			| 32'(spd) << td_pkg::F_SPEED | 32'(lst) << td_pkg::F_LAST
			| 32'(ep) << td_pkg::F_EP_LSB | 32'(ad) << td_pkg::F_ADDR_LSB
			| 32'(dr) << td_pkg::F_DIR_LSB | 32'(act) << td_pkg::F_ACTIVE;
	endfunction : mk_ctrl
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		end_of_test;
	end
	initial begin
		do_reset;
		wr(td_pkg::OFF_IRQ_ENABLE, 32'h0000_0007);
		for (int i = 0; i < 9; i++) begin
			r = rows[i];
			starts = 0;
			mf <= r.fault;
			fc <= r.fcode;
			mb <= r.maxb;
			wr(td_pkg::OFF_BUF_BASE, 32'h0000_0040);
			wr(td_pkg::OFF_DESC_COUNT, 32'(r.total));
			ctl = mk_ctrl(r.limit, 1'b0, r.iso, i[1], i[0], 4'(i + 1), 7'(i * 13 + 5), r.dir, 1'b1);
			wr(td_pkg::OFF_DESC_CTRL, ctl);
			wait_irq;
			rd(td_pkg::OFF_DESC_COUNT, v);
			check("code", v[31:28], r.code);
			if (r.code == 4'h0 || r.code == 4'h7) check("moved", v[25:16], r.moved);
			rd(td_pkg::OFF_DESC_CTRL, v);
			ctl = (ctl & 32'hEFFF_FFFF) | (32'(r.tog) << td_pkg::F_TOGGLE);
			check("ctrl", v, ctl);
			check("starts", starts, r.starts);
			if (r.starts != 4'h0) begin
				check("token", tk, {1'b0, r.iso, i[1], 4'(i + 1), 7'(i * 13 + 5), r.dir,
					(r.total < r.limit) ? r.total : r.limit});
				check("mem_addr", mem_addr >= 12'h048 &&
					mem_addr <= 12'h048 + 12'(r.total), 1'b1);
			end
			rd(td_pkg::OFF_IRQ_STATUS, v);
			check("status", v, {29'h0, r.code != 4'h0, i[0], 1'b1});
			irq_seq(3'h0, 1'b0);
			irq_seq(3'h7, 1'b1);
			wr(td_pkg::OFF_IRQ_CLEAR, 32'h0000_0007);
			repeat (3) @(posedge clk);
			#1 check("irq_clear", irq, 1'b0);
		end
		starts = 0;
		mf <= 1'b0;
		mb <= 10'h3FF;
		wr(td_pkg::OFF_DESC_COUNT, 32'h0000_0010);
		ctl = mk_ctrl(10'h004, 1'b1, 1'b0, 1'b0, 1'b1, 4'h1, 7'h05, 2'h1, 1'b1);
		wr(td_pkg::OFF_DESC_CTRL, ctl);
		wait_irq;
		check("opf_starts", starts, 4);
		check("opf_span", (t_last - t_first) >= 401, 1);
		ctl = mk_ctrl(10'h004, 1'b1, 1'b0, 1'b0, 1'b0, 4'h1, 7'h05, 2'h1, 1'b0);
		wr(td_pkg::OFF_DESC_CTRL, ctl);
		do_reset;
		rd(td_pkg::OFF_DESC_CTRL, v);
		check("opf_reset", v[td_pkg::F_OPF], 1'b0);
		for (int k = 0; k < 7; k++) begin
			if (k != 4) begin
				rd(8'(k * 4), v);
				check("reset_reg", v, 32'h0000_0000);
			end
		end
		wr(td_pkg::OFF_DESC_COUNT, 32'hFFFF_0005);
		rd(td_pkg::OFF_DESC_COUNT, v);
		check("count_ro", v, 32'h0000_0005);
		end_of_test;
	end
endmodule : testbench
`default_nettype wire
